// file: logic/ppm_pkg.sv
// Constants, types and access port structs for the power and error-check capability bank
// Operation
// - Ratio capability bit 29 reads the programmable turbo power-limit flag.
// - Ratio capability bits 47:40 read the best-efficiency ratio, 100MHz steps.
// - Idle config bits 2:0 hold a read/write package limit, factory default at reset.
// - Limit codes decode to no-package, C2, C6, C6 retained, C7, C7s, unlimited.
// - No limit code ever selects C3.
// - Bit 10 set turns I/O reads at the capture base into monitor-wait.
// - Bit 15 is a lock; once set, bits 15:0 ignore writes until reset.
// - Error-check capability is read-only; bits 7:0 give the bank count.
package ppm_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [31:0] RATIO_CAP_ADDR   = 32'h0000_00ce;
  localparam logic [31:0] IDLE_CFG_ADDR    = 32'h0000_00e2;
  localparam logic [31:0] ERR_CAP_ADDR     = 32'h0000_0179;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int TDP_PROG_BIT      = 29;
  localparam int EFF_RATIO_LSB     = 40;
  localparam int EFF_RATIO_MSB     = 47;
  localparam int LIMIT_LSB         = 0;
  localparam int LIMIT_MSB         = 2;
  localparam int IO_REDIR_BIT      = 10;
  localparam int LOCK_BIT          = 15;
  localparam int BANK_CNT_LSB      = 0;
  localparam int BANK_CNT_MSB      = 7;
  localparam int FEAT_LSB          = 8;
  localparam int FEAT_CNT          = 4;

  // ----------------------------------------------------------------------
  // Fixed capability and reset values (plain defaults)
  // ----------------------------------------------------------------------
  localparam logic       TDP_PROG_VAL   = 1'h1;
  localparam logic [7:0] EFF_RATIO_VAL  = 8'h08;
  localparam logic [7:0] BANK_CNT_VAL   = 8'h14;
  // Order: global control, extended state, corrected irq, threshold status
  localparam logic [3:0] FEAT_VAL       = 4'h5;
  localparam logic [2:0] LIMIT_RST_VAL  = 3'h7;
  localparam logic       IO_REDIR_RST   = 1'h0;
  localparam logic       LOCK_RST       = 1'h0;

  // ----------------------------------------------------------------------
  // Limit encodings
  // ----------------------------------------------------------------------
  localparam logic [2:0] LIM_NONE_PKG = 3'h0;
  localparam logic [2:0] LIM_C2       = 3'h1;
  localparam logic [2:0] LIM_C6_NORET = 3'h2;
  localparam logic [2:0] LIM_C6_RET   = 3'h3;
  localparam logic [2:0] LIM_C7       = 3'h4;
  localparam logic [2:0] LIM_C7S      = 3'h5;
  localparam logic [2:0] LIM_UNLIM    = 3'h7;

  typedef enum logic [2:0] {
    PKG_ST_C0C1,
    PKG_ST_C2,
    PKG_ST_C6_NORET,
    PKG_ST_C6_RET,
    PKG_ST_C7,
    PKG_ST_C7S,
    PKG_ST_UNLIMITED
  } ppm_pkg_state_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [31:0] addr;
    logic [63:0] wdata;
  } ppm_req_t;

  typedef struct packed {
    logic        valid;
    logic        fault;
    logic [63:0] rdata;
  } ppm_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] port;
  } ppm_io_rd_t;

endpackage

// file: logic/ppm_regs.sv
// Power, idle-state and error-check capability register bank
`timescale 1ns/1ps
module ppm_regs
  import ppm_pkg::*;
(
  input  wire logic           sys_clk_i,
  input  wire logic           reset_i,
  input  wire ppm_req_t       req_i,
  output ppm_rsp_t            rsp_o,
  input  wire logic [15:0]    io_capture_base_i,
  input  wire ppm_io_rd_t     io_rd_i,
  output logic                monitor_wait_redirect_o,
  output logic                io_read_pass_o,
  output ppm_pkg_state_t      pkg_limit_state_o,
  output logic                cfg_locked_o
);

  // ----------------------------------------------------------------------
  // Stored configuration
  // ----------------------------------------------------------------------
  logic [2:0]      limit_r;
  logic [2:0]      limit_nxt;
  logic            io_redir_r;
  logic            io_redir_nxt;
  logic            lock_r;
  logic            lock_nxt;

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  ppm_rsp_t        rsp_r;
  ppm_rsp_t        rsp_nxt;
  logic            mon_wait_r;
  logic            mon_wait_nxt;
  logic            pass_r;
  logic            pass_nxt;
  ppm_pkg_state_t  state_r;
  ppm_pkg_state_t  state_nxt;

  // ----------------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------------
  wire logic        hit_ratio = (req_i.addr == RATIO_CAP_ADDR);
  wire logic        hit_idle  = (req_i.addr == IDLE_CFG_ADDR);
  wire logic        hit_err   = (req_i.addr == ERR_CAP_ADDR);
  wire logic        hit_any   = hit_ratio | hit_idle | hit_err;
  wire logic        access    = req_i.rd | req_i.wr;

  // Writes to read-only or unmapped addresses fault; locked writes drop quietly
  wire logic        miss      = access & ~hit_any;
  wire logic        wr_ro     = req_i.wr & (hit_ratio | hit_err);
  wire logic        bad_acc   = miss | wr_ro;
  wire logic        rd_ok     = req_i.rd & ~bad_acc;
  wire logic        idle_wr   = req_i.wr & hit_idle & ~lock_r;

  // ----------------------------------------------------------------------
  // Write fields; nothing outside them is ever stored
  // ----------------------------------------------------------------------
  wire logic [2:0]  wr_limit  = req_i.wdata[LIMIT_MSB:LIMIT_LSB];
  wire logic        wr_redir  = req_i.wdata[IO_REDIR_BIT];
  wire logic        wr_lock   = req_i.wdata[LOCK_BIT];

  // ----------------------------------------------------------------------
  // Feature presence flags, one per optional error-check feature
  // ----------------------------------------------------------------------
  logic [FEAT_CNT-1:0] feat_flags;

  for (genvar f = 0; f < FEAT_CNT; f++) begin : g_feat
    assign feat_flags[f] = FEAT_VAL[f];
  end

  // ----------------------------------------------------------------------
  // Ratio capability word
  // ----------------------------------------------------------------------
  logic [63:0] ratio_word;

  always_comb begin
    ratio_word = 64'h0;
    ratio_word[TDP_PROG_BIT] = TDP_PROG_VAL;
    ratio_word[EFF_RATIO_MSB:EFF_RATIO_LSB] = EFF_RATIO_VAL;
  end

  // ----------------------------------------------------------------------
  // Idle-state configuration word
  // ----------------------------------------------------------------------
  logic [63:0] idle_word;

  always_comb begin
    idle_word = 64'h0;
    idle_word[LIMIT_MSB:LIMIT_LSB] = limit_r;
    idle_word[IO_REDIR_BIT] = io_redir_r;
    idle_word[LOCK_BIT] = lock_r;
  end

  // ----------------------------------------------------------------------
  // Error-check capability word
  // ----------------------------------------------------------------------
  logic [63:0] err_word;

  always_comb begin
    err_word = 64'h0;
    err_word[BANK_CNT_MSB:BANK_CNT_LSB] = BANK_CNT_VAL;
    err_word[FEAT_LSB +: FEAT_CNT] = feat_flags;
  end

  // ----------------------------------------------------------------------
  // Read selection and response
  // ----------------------------------------------------------------------
  wire logic [63:0] rd_mux = hit_ratio ? ratio_word :
                             hit_idle  ? idle_word  :
                             hit_err   ? err_word   : 64'h0;

  // Faulted and write cycles return zero data
  assign rsp_nxt = '{valid: access,
                     fault: bad_acc,
                     rdata: rd_ok ? rd_mux : 64'h0};

  // ----------------------------------------------------------------------
  // Configuration next values; a set lock freezes all three fields
  // ----------------------------------------------------------------------
  assign limit_nxt    = idle_wr ? wr_limit : limit_r;
  assign io_redir_nxt = idle_wr ? wr_redir : io_redir_r;
  assign lock_nxt     = idle_wr ? wr_lock  : lock_r;

  // ----------------------------------------------------------------------
  // Limit decode; code 110 has no meaning and is treated as the shallowest
  // ----------------------------------------------------------------------
  always_comb begin
    case (limit_r)
      LIM_NONE_PKG: state_nxt = PKG_ST_C0C1;
      LIM_C2:       state_nxt = PKG_ST_C2;
      LIM_C6_NORET: state_nxt = PKG_ST_C6_NORET;
      LIM_C6_RET:   state_nxt = PKG_ST_C6_RET;
      LIM_C7:       state_nxt = PKG_ST_C7;
      LIM_C7S:      state_nxt = PKG_ST_C7S;
      LIM_UNLIM:    state_nxt = PKG_ST_UNLIMITED;
      default:      state_nxt = PKG_ST_C0C1;
    endcase
  end

  // ----------------------------------------------------------------------
  // I/O read redirection
  // ----------------------------------------------------------------------
  wire logic io_hit = io_rd_i.valid & (io_rd_i.port == io_capture_base_i);
  wire logic redir  = io_hit & io_redir_r;

  // A read that is not redirected passes, so every read gets one answer
  assign mon_wait_nxt = redir;
  assign pass_nxt     = io_rd_i.valid & ~redir;

  // ----------------------------------------------------------------------
  // Configuration registers; only reset clears the lock
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      limit_r <= LIMIT_RST_VAL;
    end else begin
      limit_r <= limit_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      io_redir_r <= IO_REDIR_RST;
    end else begin
      io_redir_r <= io_redir_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lock_r <= LOCK_RST;
    end else begin
      lock_r <= lock_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Answer registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rsp_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mon_wait_r <= 1'h0;
    end else begin
      mon_wait_r <= mon_wait_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pass_r <= 1'h0;
    end else begin
      pass_r <= pass_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= PKG_ST_C0C1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Output ports
  // ----------------------------------------------------------------------
  assign rsp_o                   = rsp_r;
  assign monitor_wait_redirect_o = mon_wait_r;
  assign io_read_pass_o          = pass_r;
  assign pkg_limit_state_o       = state_r;
  assign cfg_locked_o            = lock_r;

endmodule

// file: verif/ppm_regs_assertions.sv
// Port-level assertions for the capability register bank
`timescale 1ns/1ps
module ppm_regs_assertions
  import ppm_pkg::*;
(
  input wire logic           sys_clk_i,
  input wire logic           reset_i,
  input wire ppm_req_t       req_i,
  input wire ppm_rsp_t       rsp_o,
  input wire logic [15:0]    io_capture_base_i,
  input wire ppm_io_rd_t     io_rd_i,
  input wire logic           monitor_wait_redirect_o,
  input wire logic           io_read_pass_o,
  input wire ppm_pkg_state_t pkg_limit_state_o,
  input wire logic           cfg_locked_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  wire rd_rat = req_i.rd && req_i.addr == RATIO_CAP_ADDR;
  wire rd_err = req_i.rd && req_i.addr == ERR_CAP_ADDR;
  wire wr_idl = req_i.wr && req_i.addr == IDLE_CFG_ADDR;
  wire rd_idl = req_i.rd && req_i.addr == IDLE_CFG_ADDR;
  a_tdp_flag: assert property (rd_rat |=> rsp_o.rdata[29] == TDP_PROG_VAL)
    else $error("bad tdp flag");
  a_eff_ratio: assert property (rd_rat |=> rsp_o.rdata[47:40] == EFF_RATIO_VAL)
    else $error("bad ratio");
  a_bank_count: assert property (rd_err |=> rsp_o.rdata[7:0] == BANK_CNT_VAL)
    else $error("bad bank count");
  a_feature_flags: assert property (rd_err |=> rsp_o.rdata[11:8] == FEAT_VAL)
    else $error("bad feature flags");
  // State lags the stored limit by one cycle, hence two edges
  a_limit_decode: assert property (wr_idl && !cfg_locked_o && req_i.wdata[2:0] < 3'h6
    |=> ##1 pkg_limit_state_o == ppm_pkg_state_t'($past(req_i.wdata[2:0], 2)))
    else $error("bad limit decode");
  a_lock_sticky: assert property (cfg_locked_o |=> cfg_locked_o)
    else $error("lock dropped");
  a_locked_hold: assert property (cfg_locked_o && wr_idl |=> ##1 $stable(pkg_limit_state_o))
    else $error("locked write applied");
  a_io_miss_pass: assert property (io_rd_i.valid && io_rd_i.port != io_capture_base_i
    |=> io_read_pass_o && !monitor_wait_redirect_o) else $error("miss redirected");
  a_io_one_answer: assert property (io_rd_i.valid
    |=> monitor_wait_redirect_o != io_read_pass_o) else $error("io read not answered once");
  a_idle_reserved: assert property (rd_idl |=> rsp_o.rdata[63:16] == 48'h0
    && rsp_o.rdata[14:11] == 4'h0 && rsp_o.rdata[9:3] == 7'h0) else $error("reserved bits set");
endmodule
bind ppm_regs ppm_regs_assertions u_chk (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
  .req_i(req_i), .rsp_o(rsp_o), .io_capture_base_i(io_capture_base_i), .io_rd_i(io_rd_i),
  .monitor_wait_redirect_o(monitor_wait_redirect_o), .io_read_pass_o(io_read_pass_o),
  .pkg_limit_state_o(pkg_limit_state_o), .cfg_locked_o(cfg_locked_o));

// file: verif/test_ppm_regs.sv
// Self-checking bench for the capability register bank
`timescale 1ns/1ps
module test_ppm_regs import ppm_pkg::*;;
  logic           sys_clk_i, reset_i, mw, ps, lk;
  ppm_req_t       req;
  ppm_rsp_t       rsp;
  ppm_io_rd_t     iord;
  ppm_pkg_state_t st;
  logic [15:0]    base;
  int             fails = 0, n_compared = 0, cyc = 0;
  ppm_regs u_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .req_i(req), .rsp_o(rsp),
    .io_capture_base_i(base), .io_rd_i(iord), .monitor_wait_redirect_o(mw),
    .io_read_pass_o(ps), .pkg_limit_state_o(st), .cfg_locked_o(lk));
  task automatic tally_and_finish;
    $display("fails=%0d compared=%0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [65:0] exp, input logic [65:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One access, answer checked one cycle after the request stands
  task automatic acc(input logic w, input logic [31:0] a, input logic [63:0] d,
                     input logic f, input logic [63:0] e);
    @(posedge sys_clk_i);
    req <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge sys_clk_i);
    req <= '0;
    #1 chk({1'h1, f, e}, {rsp.valid, rsp.fault, rsp.rdata});
  endtask
  task automatic io(input logic [15:0] p, input logic [1:0] e);
    @(posedge sys_clk_i);
    iord <= '{valid: 1'h1, port: p};
    @(posedge sys_clk_i);
    iord <= '0;
    #1 chk(66'(e), 66'({mw, ps}));
  endtask
  task automatic rst;
    @(posedge sys_clk_i);
    reset_i <= 1'h1;
    repeat (3) @(posedge sys_clk_i);
    reset_i <= 1'h0;
  endtask
  initial begin
    sys_clk_i = 1'h0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      tally_and_finish;
    end
  end
  initial begin
    reset_i = 1'h1;
    req = '0;
    iord = '0;
    base = 16'h00b2;
    rst;
    acc(1'h0, IDLE_CFG_ADDR, 64'h0, 1'h0, 64'(LIMIT_RST_VAL));
    chk(66'(PKG_ST_UNLIMITED), 66'(st));
    acc(1'h0, RATIO_CAP_ADDR, 64'h0, 1'h0, 64'(TDP_PROG_VAL) << 29 | 64'(EFF_RATIO_VAL) << 40);
    acc(1'h0, ERR_CAP_ADDR, 64'h0, 1'h0, {52'h0, FEAT_VAL, BANK_CNT_VAL});
    acc(1'h1, ERR_CAP_ADDR, '1, 1'h1, 64'h0);
    acc(1'h1, RATIO_CAP_ADDR, '1, 1'h1, 64'h0);
    acc(1'h0, 32'h0000_0100, 64'h0, 1'h1, 64'h0);
    acc(1'h0, ERR_CAP_ADDR, 64'h0, 1'h0, {52'h0, FEAT_VAL, BANK_CNT_VAL});
    // Reserved bits set on every write; bits 10 and 15 kept clear
    for (int c = 0; c < 8; c++) begin
      acc(1'h1, IDLE_CFG_ADDR, 64'hffff_ffff_ffff_7bf8 | 64'(c), 1'h0, 64'h0);
      acc(1'h0, IDLE_CFG_ADDR, 64'h0, 1'h0, 64'(c));
      chk(66'(c == 7 ? 6 : (c == 6 ? 0 : c)), 66'(st));
    end
    acc(1'h1, IDLE_CFG_ADDR, 64'h0401, 1'h0, 64'h0);
    io(16'h00b2, 2'h2);
    io(16'h00b3, 2'h1);
    acc(1'h1, IDLE_CFG_ADDR, 64'h0001, 1'h0, 64'h0);
    io(16'h00b2, 2'h1);
    acc(1'h1, IDLE_CFG_ADDR, 64'h8405, 1'h0, 64'h0);
    acc(1'h1, IDLE_CFG_ADDR, 64'h0000, 1'h0, 64'h0);
    acc(1'h0, IDLE_CFG_ADDR, 64'h0, 1'h0, 64'h8405);
    chk(66'({PKG_ST_C7S, 1'h1}), 66'({st, lk}));
    io(16'h00b2, 2'h2);
    @(posedge sys_clk_i);
    base <= 16'h0060;
    io(16'h0060, 2'h2);
    io(16'h00b2, 2'h1);
    rst;
    acc(1'h0, IDLE_CFG_ADDR, 64'h0, 1'h0, 64'(LIMIT_RST_VAL));
    chk(66'h0, 66'(lk));
    tally_and_finish;
  end
endmodule
